/* pdsr_pkg.sv */
// Package: constants and types for the pre-driver serial control front end
package pdsr_pkg;
    localparam int unsigned FRAME_BITS = 16;
    localparam int unsigned ADDR_MSB = 15;
    localparam int unsigned ADDR_LSB = 13;
    localparam int unsigned DATA_MSB = 12;
    localparam int unsigned DATA_LSB = 1;
    localparam int unsigned PAR_BIT = 0;
    localparam int unsigned NUM_CH = 6;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned CLK_MHZ = 50;
    // Timer clock is 4.17 MHz: 12 reference cycles, divider toggles each 6
    localparam int unsigned TMR_CLK_KHZ = 4000;
    localparam int unsigned TMR_DIV = CLK_MHZ * 1000 / TMR_CLK_KHZ / 2;
    // Register addresses
    localparam logic [2:0] ADDR_GATE = 3'h0;
    localparam logic [2:0] ADDR_STAT_LO = 3'h4;
    localparam logic [2:0] ADDR_STAT_HI = 3'h5;
    localparam logic [2:0] ADDR_REV = 3'h6;
    localparam logic [2:0] ADDR_ERR = 3'h7;
    // Response patterns
    localparam logic [11:0] ERR_PAT = 12'h554;
    localparam logic [1:0] PAR_ERR_TAIL = 2'h2;
    localparam logic [1:0] FRM_ERR_TAIL = 2'h1;
    localparam logic [5:0] REV_PREFIX = 6'h01;
    localparam logic [11:0] GATE_RST = 12'h000;
    typedef enum logic [1:0] {RSP_ECHO, RSP_REV, RSP_PERR, RSP_FERR} pdsr_rsp_e;
endpackage : pdsr_pkg

/* pdsr_word_if.sv */
// Interface: valid/ready word carrier between serial core and FIFO
`timescale 1ns/100ps
interface pdsr_word_if #(parameter int unsigned W = 16);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : pdsr_word_if

/* pdsr_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module pdsr_fifo #(
    parameter int unsigned W = 16,
    parameter int unsigned DEPTH = 8
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    pdsr_word_if.snk wr,
    pdsr_word_if.src rd
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW:0] wp_q, wp_d, rp_q, rp_d;
    logic [W-1:0] out_q, out_d;
    logic ov_q, ov_d;
    logic push, pop, full, empty;

    // Pointer flags and next state
    always_comb begin
        full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
        empty = (wp_q == rp_q);
        push = wr.valid && !full;
        pop = !empty && (!ov_q || rd.ready);
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
        out_d = pop ? mem_q[rp_q[AW-1:0]] : out_q;
        ov_d = pop ? 1'b1 : (rd.ready ? 1'b0 : ov_q);
    end

    assign wr.ready = !full;
    assign rd.valid = ov_q;
    assign rd.data = out_q;

    // Register pointers and the output word
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wp_q <= '0;
            rp_q <= '0;
            out_q <= '0;
            ov_q <= 1'b0;
        end else if (i_ce) begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            out_q <= out_d;
            ov_q <= ov_d;
        end
    end

    // Storage array, no reset needed
    always_ff @(posedge i_ref_clk) begin
        if (i_ce && push) begin
            mem_q[wp_q[AW-1:0]] <= wr.data;
        end
    end
endmodule : pdsr_fifo

/* pdsr_cmd_dec.sv */
// Command decoder: applies accepted words to gate and mode settings
`timescale 1ns/100ps
module pdsr_cmd_dec
    import pdsr_pkg::*;
#(
    parameter int unsigned NCH = NUM_CH
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_clr,
    pdsr_word_if.snk cmd,
    output logic [NCH-1:0] o_gate_on,
    output logic [NCH-1:0] o_retry_mode
);
    logic [11:0] gate_q, gate_d;

    // Take one word per cycle; only gate register content is kept here
    always_comb begin
        gate_d = gate_q;
        if (i_clr) begin
            gate_d = GATE_RST;
        end else if (cmd.valid
                     && cmd.data[ADDR_MSB:ADDR_LSB] == ADDR_GATE) begin
            gate_d = cmd.data[DATA_MSB:DATA_LSB];
        end
    end

    assign cmd.ready = 1'b1;
    assign o_gate_on = gate_q[NCH-1:0];
    assign o_retry_mode = gate_q[2*NCH-1:NCH];

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            gate_q <= GATE_RST;
        end else if (i_ce) begin
            gate_q <= gate_d;
        end
    end
endmodule : pdsr_cmd_dec

/* pdsr_spi_ctrl.sv */
// Serial front end of the six-channel pre-driver with reset and enable
`timescale 1ns/100ps
// Summary of operation
// - Supply below threshold: gates low, defaults, flag off
// - Falling supply: flag off, gates held low
// - Master reset low disables gates, timer, serial, flag
// - Reset release restores defaults, enables serial and flag
// - Enable high: gates off, retry timer reset
// - Enable high keeps serial, faults and registers
// - Enable low again re-enables faulted outputs
// - Odd parity check on every received word
// - Frame must be multiple of 16 clocks
// - Parity and frame errors never touch fault flag
// - Full duplex, MSB first, on host shift clock
// - Output on falling edge, sample on rising
// - Select fall: reset frame check, load reply, clear flag
// - Select rise, valid: decode last word, flag fault
// - Select rise, error: drop command, keep faults
// - Works alone or daisy-chained with 16-bit devices
// - Word is address, twelve data bits, parity
// - Reply echoes previous address with selected content
// - First reply after reset is revision information
module pdsr_spi_ctrl
    import pdsr_pkg::*;
#(
    parameter int unsigned NCH = NUM_CH,
    parameter logic [5:0] REVISION = 6'h11  // Arbitrary revision value
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_logic_supply_ok,
    input wire logic i_master_reset_n,
    input wire logic i_global_enable_n,
    input wire logic i_chip_select_n,
    input wire logic i_sclk,
    input wire logic i_sdi,
    input wire logic [NCH-1:0] i_ch_fault,
    input wire logic [3*NCH-1:0] i_ch_status,
    output logic o_sdo,
    output logic o_sdo_oe,
    output logic o_fault_flag_n_oe,
    output logic [NCH-1:0] o_gate_drive_out,
    output logic o_timer_clk,
    output logic o_retry_clr
);
    // Two-stage synchronisers for the six control and serial pins; channel fault and status inputs are not synchronised
    // Reset values are the idle pin levels, so no false select edge follows
    logic [5:0] s1_q, s2_q;
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s1_q <= 6'h07;
            s2_q <= 6'h07;
        end else if (i_ce) begin
            s1_q <= {i_sdi, i_sclk, i_global_enable_n, i_chip_select_n,
                     i_master_reset_n, i_logic_supply_ok};
            s2_q <= s1_q;
        end
    end
    logic supply_ok, mrst_n, cs_n, en_n, sclk, sdi;
    assign {sdi, sclk, en_n, cs_n, mrst_n, supply_ok} = s2_q;
    // Device is held in reset by low supply or master reset
    logic run;
    assign run = supply_ok && mrst_n;

    // Serial state
    logic sclk_p_q, sclk_p_d, cs_p_q, cs_p_d;
    logic [15:0] rx_q, rx_d, tx_q, tx_d;
    logic [3:0] cnt_q, cnt_d;
    logic any_q, any_d;
    logic [2:0] last_addr_q, last_addr_d;
    logic [11:0] last_data_q, last_data_d;
    pdsr_rsp_e rsp_q, rsp_d;
    logic sdo_q, sdo_d, oe_q, oe_d;
    logic flt_en_q, flt_en_d;
    logic push;
    logic [15:0] push_word;
    logic sclk_rise, sclk_fall, cs_fall, cs_rise, perr;
    logic [15:0] reply;

    pdsr_word_if #(.W(FRAME_BITS)) w_in();
    pdsr_word_if #(.W(FRAME_BITS)) w_out();

    // Reply word: previous address echo plus selected content
    always_comb begin
        reply = {last_addr_q, last_data_q, 1'b0};
        unique case (rsp_q)
            RSP_REV: reply = {ADDR_REV, REV_PREFIX, REVISION, 1'b0};
            // Error tails hold the last data bit and the parity bit
            RSP_PERR: reply = {ADDR_ERR, ERR_PAT[11:1], PAR_ERR_TAIL};
            RSP_FERR: reply = {ADDR_ERR, ERR_PAT[11:1], FRM_ERR_TAIL};
            RSP_ECHO: begin
                if (last_addr_q == ADDR_STAT_LO) begin
                    reply[12:1] = {2'b00, en_n, i_ch_status[8:0]};
                end else if (last_addr_q == ADDR_STAT_HI) begin
                    reply[12:1] = {2'b00, en_n, i_ch_status[17:9]};
                end
            end
        endcase
        if (rsp_q != RSP_PERR && rsp_q != RSP_FERR) begin
            reply[PAR_BIT] = ~^reply[15:1];  // Odd parity on reply
        end
    end

    // Edge detection and frame handling
    always_comb begin
        sclk_rise = sclk && !sclk_p_q;
        sclk_fall = !sclk && sclk_p_q;
        cs_fall = !cs_n && cs_p_q;
        cs_rise = cs_n && !cs_p_q;
        perr = ~^rx_q;  // Even count of ones is an error
        sclk_p_d = sclk;
        cs_p_d = cs_n;
        rx_d = rx_q;
        tx_d = tx_q;
        cnt_d = cnt_q;
        any_d = any_q;
        last_addr_d = last_addr_q;
        last_data_d = last_data_q;
        rsp_d = rsp_q;
        sdo_d = sdo_q;
        oe_d = !cs_n;  // Released while select high
        flt_en_d = flt_en_q;
        push = 1'b0;
        push_word = rx_q;
        if (cs_fall) begin
            cnt_d = '0;
            any_d = 1'b0;
            tx_d = {reply[14:0], 1'b0};
            sdo_d = reply[15];  // MSB first
            flt_en_d = 1'b0;
        end else if (!cs_n) begin
            if (sclk_rise) begin
                rx_d = {rx_q[14:0], sdi};
                cnt_d = cnt_q + 4'h1;
                any_d = 1'b1;
            end
            if (sclk_fall && any_q) begin
                sdo_d = tx_q[15];
                tx_d = {tx_q[14:0], sdi};  // Pass-through for chaining
            end
        end
        if (cs_rise) begin
            flt_en_d = 1'b1;  // Errors do not gate the flag
            if (cnt_q != 4'h0 || !any_q) begin
                rsp_d = RSP_FERR;
            end else if (perr) begin
                rsp_d = RSP_PERR;
            end else begin
                push = 1'b1;
                last_addr_d = rx_q[ADDR_MSB:ADDR_LSB];
                last_data_d = rx_q[DATA_MSB:DATA_LSB];
                rsp_d = RSP_ECHO;
            end
        end
    end

    assign w_in.valid = push;
    assign w_in.data = push_word;

    // Serial registers; low supply or master reset returns defaults
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sclk_p_q <= 1'b0;
            cs_p_q <= 1'b1;
            rx_q <= '0;
            tx_q <= '0;
            cnt_q <= '0;
            any_q <= 1'b0;
            last_addr_q <= '0;
            last_data_q <= '0;
            rsp_q <= RSP_REV;
            sdo_q <= 1'b0;
            oe_q <= 1'b0;
            flt_en_q <= 1'b1;  // Flag enabled out of reset
        end else if (i_ce) begin
            if (!run) begin
                sclk_p_q <= 1'b0;
                cs_p_q <= 1'b1;
                rx_q <= '0;
                tx_q <= '0;
                cnt_q <= '0;
                any_q <= 1'b0;
                last_addr_q <= '0;
                last_data_q <= '0;
                rsp_q <= RSP_REV;
                sdo_q <= 1'b0;
                oe_q <= 1'b0;
                flt_en_q <= 1'b1;  // Re-enabled on release
            end else begin
                sclk_p_q <= sclk_p_d;
                cs_p_q <= cs_p_d;
                rx_q <= rx_d;
                tx_q <= tx_d;
                cnt_q <= cnt_d;
                any_q <= any_d;
                last_addr_q <= last_addr_d;
                last_data_q <= last_data_d;
                rsp_q <= rsp_d;
                sdo_q <= sdo_d;
                oe_q <= oe_d;
                flt_en_q <= flt_en_d;
            end
        end
    end

    // Command path buffered, then decoded
    pdsr_fifo #(.W(FRAME_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .wr(w_in),
        .rd(w_out)
    );
    logic [NCH-1:0] gate_on, retry_mode;
    pdsr_cmd_dec #(.NCH(NCH)) u_dec (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_clr(!run),
        .cmd(w_out),
        .o_gate_on(gate_on),
        .o_retry_mode(retry_mode)
    );

    // Latched fault shutdown and gate outputs
    logic [NCH-1:0] latch_q, latch_d, gate_q, gate_d;
    logic fltoe_q, fltoe_d, tclk_q, tclk_d, rclr_q, rclr_d;
    logic en_p_q, en_p_d;
    logic [3:0] div_q, div_d;
    always_comb begin
        en_p_d = en_n;
        latch_d = latch_q | (i_ch_fault & ~retry_mode);
        // Enable returned low clears old shutdowns; a new fault still latches
        if (!en_n && en_p_q) begin
            latch_d = i_ch_fault & ~retry_mode;
        end
        if (!en_n) begin
            gate_d = gate_on & ~latch_q & ~i_ch_fault;
        end else begin
            gate_d = '0;
        end
        rclr_d = en_n;  // Retry timer held cleared
        fltoe_d = flt_en_q && (|i_ch_fault) && cs_n;
        div_d = div_q + 4'h1;
        tclk_d = tclk_q;
        if (div_q == 4'(TMR_DIV - 1)) begin
            div_d = '0;
            tclk_d = !tclk_q;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            latch_q <= '0;
            gate_q <= '0;
            fltoe_q <= 1'b0;
            tclk_q <= 1'b0;
            rclr_q <= 1'b1;
            div_q <= '0;
            en_p_q <= 1'b0;
        end else if (i_ce) begin
            if (!run) begin
                latch_q <= '0;
                gate_q <= '0;
                fltoe_q <= 1'b0;
                tclk_q <= 1'b0;  // Timer clock stopped
                rclr_q <= 1'b1;
                div_q <= '0;
                en_p_q <= 1'b0;
            end else begin
                latch_q <= latch_d;
                gate_q <= gate_d;
                fltoe_q <= fltoe_d;
                tclk_q <= tclk_d;
                rclr_q <= rclr_d;
                div_q <= div_d;
                en_p_q <= en_p_d;
            end
        end
    end

    assign o_sdo = sdo_q;
    assign o_sdo_oe = oe_q;
    assign o_fault_flag_n_oe = fltoe_q;
    assign o_gate_drive_out = gate_q;
    assign o_timer_clk = tclk_q;
    assign o_retry_clr = rclr_q;
endmodule : pdsr_spi_ctrl

/* pdsr_spi_ctrl_properties.sv */
// Checker: port-level properties of the serial control front end
`timescale 1ns/100ps
module pdsr_spi_ctrl_chk
    import pdsr_pkg::*;
#(
    parameter int unsigned NCH = NUM_CH
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_logic_supply_ok,
    input wire logic i_master_reset_n,
    input wire logic i_global_enable_n,
    input wire logic i_chip_select_n,
    input wire logic [NCH-1:0] i_ch_fault,
    input wire logic o_sdo_oe,
    input wire logic o_fault_flag_n_oe,
    input wire logic [NCH-1:0] o_gate_drive_out,
    input wire logic o_timer_clk,
    input wire logic o_retry_clr
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    logic run;
    // Device powered and out of master reset
    assign run = i_master_reset_n && i_logic_supply_ok;
    property p_sdo_off;
        i_chip_select_n [*5] |-> !o_sdo_oe;
    endproperty
    a_sdo_off: assert property (p_sdo_off)
        else $error("sdo driven while deselected");
    property p_sdo_on;
        (!i_chip_select_n && run) [*6] |-> o_sdo_oe;
    endproperty
    a_sdo_on: assert property (p_sdo_on)
        else $error("sdo not driven in frame");
    property p_flag_cs;
        !i_chip_select_n [*5] |-> !o_fault_flag_n_oe;
    endproperty
    a_flag_cs: assert property (p_flag_cs)
        else $error("fault flag active in frame");
    property p_flag_src;
        $rose(o_fault_flag_n_oe) |-> $past(i_chip_select_n, 4);
    endproperty
    a_flag_src: assert property (p_flag_src)
        else $error("fault flag rose inside frame");
    property p_flag_on;
        (i_chip_select_n && |i_ch_fault && run && !i_global_enable_n) [*8]
            |-> o_fault_flag_n_oe;
    endproperty
    a_flag_on: assert property (p_flag_on)
        else $error("fault not flagged");
    property p_rst_off;
        !i_master_reset_n [*5] |-> o_gate_drive_out == '0 && !o_sdo_oe
            && !o_fault_flag_n_oe;
    endproperty
    a_rst_off: assert property (p_rst_off)
        else $error("outputs active in master reset");
    property p_tmr_stop;
        !i_master_reset_n [*5] |=> $stable(o_timer_clk);
    endproperty
    a_tmr_stop: assert property (p_tmr_stop)
        else $error("timer clock runs in master reset");
    property p_tmr_half;
        $rose(o_timer_clk) ##1 run [*6] |-> $fell(o_timer_clk);
    endproperty
    a_tmr_half: assert property (p_tmr_half)
        else $error("timer clock half period wrong");
    property p_pwr_off;
        !i_logic_supply_ok [*5] |-> o_gate_drive_out == '0
            && !o_fault_flag_n_oe;
    endproperty
    a_pwr_off: assert property (p_pwr_off)
        else $error("outputs active with supply low");
    property p_en_off;
        i_global_enable_n [*5] |-> o_gate_drive_out == '0 && o_retry_clr;
    endproperty
    a_en_off: assert property (p_en_off)
        else $error("gates on or retry live while disabled");
    // Main scenarios reached
    c_frame: cover property ($fell(i_chip_select_n) ##[1:20] o_sdo_oe);
    c_flag: cover property ($rose(o_fault_flag_n_oe));
    c_gate: cover property ($changed(o_gate_drive_out));
endmodule : pdsr_spi_ctrl_chk

bind pdsr_spi_ctrl pdsr_spi_ctrl_chk #(.NCH(NCH)) i_chk (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_logic_supply_ok(i_logic_supply_ok),
    .i_master_reset_n(i_master_reset_n),
    .i_global_enable_n(i_global_enable_n),
    .i_chip_select_n(i_chip_select_n), .i_ch_fault(i_ch_fault),
    .o_sdo_oe(o_sdo_oe), .o_fault_flag_n_oe(o_fault_flag_n_oe),
    .o_gate_drive_out(o_gate_drive_out), .o_timer_clk(o_timer_clk),
    .o_retry_clr(o_retry_clr)
);

/* pdsr_host_model.sv */
// Host model: serial master driving select, shift clock and data in
`timescale 1ns/100ps
module pdsr_host_model (
    input wire logic i_ref_clk,
    input wire logic i_sdo,
    input wire logic i_sdo_oe,
    output logic o_chip_select_n,
    output logic o_sclk,
    output logic o_sdi
);
    logic sdo_last = 1'b0;
    logic sdo_line;
    // Released line has no pull, so it shows the inverse of the last bit
    always @(posedge i_ref_clk) if (i_sdo_oe) sdo_last <= i_sdo;
    assign sdo_line = i_sdo_oe ? i_sdo : ~sdo_last;
    // Idle levels of the pulled lines
    initial begin
        o_chip_select_n = 1'b1;
        o_sclk = 1'b0;
        o_sdi = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #2;
    endtask : tick
    // One frame of n shift clocks of 160 ns, MSB first both ways
    task automatic xfer(input logic [31:0] w, input int n,
                        output logic [31:0] r);
        r = '0;
        o_chip_select_n = 1'b0;
        tick(8);
        for (int i = n - 1; i >= 0; i--) begin
            o_sdi = w[i];
            tick(5);
            r[i] = sdo_line;
            o_sclk = 1'b1;
            tick(3);
            o_sclk = 1'b0;
        end
        tick(4);
        o_chip_select_n = 1'b1;
        o_sdi = 1'b0;
        tick(80);
    endtask : xfer
endmodule : pdsr_host_model

/* tb.sv */
// Testbench: self-checking run of the serial control front end
`timescale 1ns/100ps
module tb;
    import pdsr_pkg::*;
    localparam logic [5:0] REV = 6'h2a; // Arbitrary revision value
    localparam logic [15:0] PERR = {3'h7, 11'h2aa, 2'h2};
    localparam logic [15:0] FERR = {3'h7, 11'h2aa, 2'h1};
    logic clk = 1'b0;
    logic nrst, sup_ok, mrst_n, en_n, cs_n, sclk, sdi;
    logic sdo, sdo_oe, flag_oe, tclk, rclr;
    logic [5:0] fault, gates;
    logic [31:0] r;
    int mismatches = 0;
    int cmp_count = 0;
    always #10 clk = ~clk;
    pdsr_spi_ctrl #(.REVISION(REV)) i_dut (
        .i_ref_clk(clk), .i_nrst(nrst), .i_ce(1'b1),
        .i_logic_supply_ok(sup_ok), .i_master_reset_n(mrst_n),
        .i_global_enable_n(en_n), .i_chip_select_n(cs_n), .i_sclk(sclk),
        .i_sdi(sdi), .i_ch_fault(fault), .i_ch_status(18'h0a5c3),
        .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_fault_flag_n_oe(flag_oe),
        .o_gate_drive_out(gates), .o_timer_clk(tclk), .o_retry_clr(rclr));
    pdsr_host_model i_host (.i_ref_clk(clk), .i_sdo(sdo),
        .i_sdo_oe(sdo_oe), .o_chip_select_n(cs_n), .o_sclk(sclk),
        .o_sdi(sdi));
    // Word with odd parity in the lowest bit
    function automatic logic [15:0] wp(input logic [14:0] b);
        return {b, ~^b};
    endfunction : wp
    task automatic chk(input string n, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : wait_clk
    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    // Quiet outputs after reset, timer clock running
    task automatic t_idle();
        logic t0;
        int k;
        chk("gates", gates, 0);
        chk("flag", flag_oe, 0);
        chk("sdo_oe", sdo_oe, 0);
        chk("retry_clr", rclr, 0);
        t0 = tclk;
        for (k = 0; k < 20 && tclk === t0; k++) wait_clk(1);
        chk("timer", k < 20, 1);
        if (k == 20) final_report();
    endtask : t_idle
    // First reply, echo, parity and frame errors, long frames
    task automatic t_frames();
        i_host.xfer(wp({3'h0, 12'h02d}), 16, r);
        chk("rev", r, wp({3'h6, 6'h01, REV}));
        chk("gates", gates, 6'h2d);
        i_host.xfer(wp({3'h0, 12'h03f}) ^ 16'h1, 16, r);
        chk("echo", r, wp({3'h0, 12'h02d}));
        chk("gates", gates, 6'h2d);
        i_host.xfer(wp({3'h0, 12'h000}), 15, r);
        chk("perr", r[14:0], PERR[15:1]);
        chk("gates", gates, 6'h2d);
        i_host.xfer({wp({3'h4, 12'h0}), wp({3'h0, 12'h015})}, 32, r);
        chk("ferr", r[31:16], FERR);
        chk("gates", gates, 6'h15);
        i_host.xfer(0, 0, r);
        i_host.xfer(wp({3'h0, 12'h015}), 16, r);
        chk("ferr0", r, FERR);
    endtask : t_frames
    // Channel fault shown on the flag, kept across a parity error
    task automatic t_fault();
        fault = 6'h04;
        wait_clk(10);
        chk("flag", flag_oe, 1);
        i_host.xfer(wp({3'h0, 12'h015}) ^ 16'h1, 16, r);
        chk("echo", r, wp({3'h0, 12'h015}));
        chk("flag", flag_oe, 1);
        fault = 6'h00;
    endtask : t_fault
    // Global disable keeps serial access and settings
    task automatic t_enable();
        en_n = 1'b1;
        wait_clk(6);
        chk("gates", gates, 0);
        chk("retry_clr", rclr, 1);
        i_host.xfer(wp({3'h0, 12'h035}), 16, r);
        chk("perr", r, PERR);
        chk("gates", gates, 0);
        en_n = 1'b0;
        wait_clk(6);
        chk("gates", gates, 6'h35);
    endtask : t_enable
    // Master reset stops everything, release restores defaults
    task automatic t_mreset();
        logic t0;
        mrst_n = 1'b0;
        wait_clk(6);
        chk("gates", gates, 0);
        chk("flag", flag_oe, 0);
        t0 = tclk;
        wait_clk(12);
        chk("timer", tclk, t0);
        mrst_n = 1'b1;
        wait_clk(6);
        chk("gates", gates, 0);
        i_host.xfer(wp({3'h0, 12'h007}), 16, r);
        chk("rev", r, wp({3'h6, 6'h01, REV}));
        chk("gates", gates, 6'h07);
    endtask : t_mreset
    // Supply below threshold acts as power-on reset
    task automatic t_supply();
        sup_ok = 1'b0;
        wait_clk(6);
        chk("gates", gates, 0);
        chk("flag", flag_oe, 0);
        sup_ok = 1'b1;
        wait_clk(6);
        i_host.xfer(wp({3'h4, 12'h0}), 16, r);
        chk("rev", r, wp({3'h6, 6'h01, REV}));
        chk("gates", gates, 0);
        // Status replies for both channel groups, enable bit low
        i_host.xfer(wp({3'h5, 12'h0}), 16, r);
        chk("stat_lo", r, wp({3'h4, 12'h1c3}));
        i_host.xfer(wp({3'h0, 12'h0}), 16, r);
        chk("stat_hi", r, wp({3'h5, 12'h052}));
    endtask : t_supply
    // Main sequence
    initial begin
        nrst = 1'b0;
        sup_ok = 1'b1;
        mrst_n = 1'b1;
        en_n = 1'b0;
        fault = '0;
        repeat (5) @(posedge clk);
        #2 nrst = 1'b1;
        wait_clk(6);
        t_idle();
        t_frames();
        t_fault();
        t_enable();
        t_mreset();
        t_supply();
        final_report();
    end
endmodule : tb
